// *** include/capture_path_pkg.sv ***
// Purpose: constants for the capture path control block and its sample FIFO
// Assumes: registers sit in page 1 of the microcontroller space (0xA1xx)
// Notes:   gain tables are Q8 fixed point, 1.0 = 256
//
// Functional notes
// RL1 - right analog gain, 4 bits, 0..22.5 dB
// RL2 - mute bit 7 silences stage, resets muted
// RL3 - muted stages still deliver samples
// RL4 - source select bit0 left, bit4 right
// RL5 - filter hold bit 4, resets off
// RL6 - filter bypass bit 6, resets off
// RL7 - second gain code inverted, resets Fh
// RL8 - sixteen 1.5 dB digital gain steps
// RL9 - boost applied before output gain
// RL10 - boost fields [1:0] right, [5:4] left
// RL11 - mode bit 0 picks analog/digital port
// RL12 - shared pins change function with mode
// RL13 - mode bit 1 swaps left/right outputs
// RL14 - mode bit 2 copies left to right
// RL15 - mode bit 3 inverts incoming mic bits
// RL16 - mode bit 7 shuts analog mic down
// RL17 - swap plus mono give any capture mix
// RL18 - first gain steps 1.5 dB, sixteen codes
// RL19 - swap/mono/invert add no latency
// RL20 - reserved bits store written value
package capture_path_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [15:0] PAGE_BASE         = 16'hA100;
    localparam logic [7:0]  OFF_FIRST_R_GAIN  = 8'hB1;
    localparam logic [7:0]  OFF_FIRST_SRC     = 8'hB2;
    localparam logic [7:0]  OFF_FIRST_FILT    = 8'hB3;
    localparam logic [7:0]  OFF_SECOND_L_GAIN = 8'hB4;
    localparam logic [7:0]  OFF_SECOND_R_GAIN = 8'hB5;
    localparam logic [7:0]  OFF_SECOND_BOOST  = 8'hB6;
    localparam logic [7:0]  OFF_SECOND_FILT   = 8'hB7;
    localparam logic [7:0]  OFF_MIC_PORT_MODE      = 8'hB8;
    localparam int          NUM_REGS          = 8;

    localparam logic [2:0] IDX_FIRST_R_GAIN  = 3'(OFF_FIRST_R_GAIN - 8'hB1);
    localparam logic [2:0] IDX_FIRST_SRC     = 3'(OFF_FIRST_SRC - 8'hB1);
    localparam logic [2:0] IDX_FIRST_FILT    = 3'(OFF_FIRST_FILT - 8'hB1);
    localparam logic [2:0] IDX_SECOND_L_GAIN = 3'(OFF_SECOND_L_GAIN - 8'hB1);
    localparam logic [2:0] IDX_SECOND_R_GAIN = 3'(OFF_SECOND_R_GAIN - 8'hB1);
    localparam logic [2:0] IDX_SECOND_BOOST  = 3'(OFF_SECOND_BOOST - 8'hB1);
    localparam logic [2:0] IDX_SECOND_FILT   = 3'(OFF_SECOND_FILT - 8'hB1);
    localparam logic [2:0] IDX_MIC_PORT_MODE      = 3'(OFF_MIC_PORT_MODE - 8'hB1);

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int GAIN_LSB      = 0;
    localparam int MUTE_BIT      = 7;
    localparam int LEFT_SRC_BIT  = 0;
    localparam int RIGHT_SRC_BIT = 4;
    localparam int HOLD_BIT      = 4;
    localparam int BYPASS_BIT    = 6;
    localparam int RBOOST_LSB    = 0;
    localparam int LBOOST_LSB    = 4;
    localparam int PORT_TYPE_BIT = 0;
    localparam int EXCH_BIT      = 1;
    localparam int MONO_BIT      = 2;
    localparam int INV_BIT       = 3;
    localparam int SHUTDOWN_BIT  = 7;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_FIRST_R_GAIN = 8'h80;
    localparam logic [7:0] RST_FIRST_SRC    = 8'h00;
    localparam logic [7:0] RST_FILT         = 8'h00;
    localparam logic [7:0] RST_SECOND_GAIN  = 8'h8F;
    localparam logic [7:0] RST_BOOST        = 8'h33;
    localparam logic [7:0] RST_MIC_PORT_MODE     = 8'h80;

    ////////////////////////////////////////////////////////////////////////
    // shared port pins
    localparam int PIN_CLK_OR_LBIAS  = 0;
    localparam int PIN_DATA_A        = 1;
    localparam int PIN_DATA_B        = 2;
    localparam int PIN_CSEL_OR_RBIAS = 3;

    ////////////////////////////////////////////////////////////////////////
    // datapath and timing
    localparam int SAMPLE_W     = 24;
    localparam int FIFO_DEPTH   = 8;
    localparam int GAIN_FRAC    = 8;
    localparam int MIC_CLK_HALF = 10; // mclk cycles per half mic clock
    // index = number of 1.5 dB steps above 0 dB
    localparam logic [15:0][13:0] STEP_GAIN_Q8 = {
        14'h0D4F, 14'h0B34, 14'h096E, 14'h07EF,
        14'h06AF, 14'h059F, 14'h04BB, 14'h03FB,
        14'h035A, 14'h02D2, 14'h0260, 14'h01FF,
        14'h01AE, 14'h016A, 14'h0130, 14'h0100};
    // index = boost code: 30, 20, 10, 0 dB
    localparam logic [3:0][13:0] BOOST_Q8 = {
        14'h0100, 14'h032A, 14'h0A00, 14'h1FA0};

endpackage

// *** include/capture_fifo_if.sv ***
// Purpose: push and pop handshake between capture path and its FIFO
// Assumes: single clock domain
// Notes:   store is the FIFO end, user is the capture path end
`timescale 1ns/1ns
interface capture_fifo_if #(parameter int WIDTH = 48);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport store (
        input  push_valid,
        input  push_data,
        input  pop_ready,
        output push_ready,
        output pop_valid,
        output pop_data
    );
    modport user (
        output push_valid,
        output push_data,
        output pop_ready,
        input  push_ready,
        input  pop_valid,
        input  pop_data
    );
endinterface

// *** rtl/sample_fifo.sv ***
// Purpose: stereo sample buffer with registered read word
// Assumes: pop side may stall at any time
// Notes:   depth counts stored words; the output register is one extra
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 2 * capture_path_pkg::SAMPLE_W,
    parameter int DEPTH = capture_path_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic nrst,
    capture_fifo_if.store port
);
    import capture_path_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [CW-1:0]               cnt;
        logic                        ov;
        logic [WIDTH-1:0]            od;
    } fifo_st_t;

    fifo_st_t s_reg;
    fifo_st_t s_next;
    logic     full;
    logic     push;
    logic     take;

    ////////////////////////////////////////////////////////////////////////
    // full refuses pushes even when a pop frees a slot, keeps ready simple
    assign full = (s_reg.cnt == CW'(DEPTH));
    assign push = port.push_valid && !full;
    assign take = (s_reg.cnt != '0) && (!s_reg.ov || port.pop_ready);

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr] = port.push_data;
            s_next.wr = (s_reg.wr == AW'(DEPTH - 1)) ? '0 : s_reg.wr + 1'b1;
        end
        if (take) begin
            s_next.od = s_reg.mem[s_reg.rd];
            s_next.ov = 1'b1;
            s_next.rd = (s_reg.rd == AW'(DEPTH - 1)) ? '0 : s_reg.rd + 1'b1;
        end else if (port.pop_ready) begin
            s_next.ov = 1'b0;
        end
        s_next.cnt = s_reg.cnt + CW'(push) - CW'(take);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // handshake outputs
    assign port.push_ready = !full;
    assign port.pop_valid  = s_reg.ov;
    assign port.pop_data   = s_reg.od;
endmodule

// *** rtl/capture_path_ctrl.sv ***
// Purpose: record path control registers and second converter processing
// Assumes: register port is the microcontroller page-1 space on mclk
// Notes:   samples are signed, left in the upper half of the FIFO word
`timescale 1ns/1ns
module capture_path_ctrl #(
    parameter int SAMPLE_W  = capture_path_pkg::SAMPLE_W,
    parameter int FIFO_DEP  = capture_path_pkg::FIFO_DEPTH,
    parameter int CLK_HALF  = capture_path_pkg::MIC_CLK_HALF
) (
    input  wire logic                mclk,
    input  wire logic                nrst,
    input  wire logic [15:0]         reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    input  wire logic                sample_valid,
    output logic                     sample_ready,
    input  wire logic [SAMPLE_W-1:0] sample_left,
    input  wire logic [SAMPLE_W-1:0] sample_right,
    output logic                     out_valid,
    input  wire logic                out_ready,
    output logic      [SAMPLE_W-1:0] out_left,
    output logic      [SAMPLE_W-1:0] out_right,
    input  wire logic [3:0]          shared_pin_in,
    output logic      [3:0]          shared_pin_out,
    output logic      [3:0]          shared_pin_oe_n,
    input  wire logic                left_bias_level,
    input  wire logic                right_bias_level,
    input  wire logic                chan_sel_level,
    output logic                     mic_bit_a,
    output logic                     mic_bit_b,
    output logic      [3:0]          first_right_analog_gain,
    output logic                     first_right_mute,
    output logic                     first_left_source_sel,
    output logic                     first_right_source_sel,
    output logic                     first_highpass_hold,
    output logic                     first_highpass_bypass,
    output logic                     second_highpass_hold,
    output logic                     second_highpass_bypass,
    output logic                     mic_port_type,
    output logic                     analog_mic_shutdown
);
    import capture_path_pkg::*;

    localparam int PW = SAMPLE_W + 15;

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic [7:0]               rdata;
        logic [1:0]               sync1;
        logic [1:0]               sync2;
        logic [1:0]               mic_bits;
        logic [7:0]               div_cnt;
        logic                     mic_clk;
        logic [3:0]               pin_out;
        logic [3:0]               pin_oe_n;
        logic                     ovalid;
        logic [SAMPLE_W-1:0]      oleft;
        logic [SAMPLE_W-1:0]      oright;
    } ctrl_st_t;

    ctrl_st_t s_reg;
    ctrl_st_t s_next;

    capture_fifo_if #(.WIDTH(2 * SAMPLE_W)) fifo_bus ();

    ////////////////////////////////////////////////////////////////////////
    // address decode: {hit, index}
    function automatic logic [3:0] decode(input logic [15:0] addr);
        logic [7:0] off;
        off = addr[7:0];
        if (addr[15:8] == PAGE_BASE[15:8] && off >= OFF_FIRST_R_GAIN &&
            off <= OFF_MIC_PORT_MODE) begin
            return {1'b1, 3'(off - OFF_FIRST_R_GAIN)};
        end
        return 4'h0;
    endfunction

    // signed Q8 scale with saturation to the sample width
    function automatic logic [SAMPLE_W-1:0] scale(
        input logic [SAMPLE_W-1:0] smp,
        input logic [13:0]         q
    );
        logic signed [PW-1:0] p;
        logic signed [PW-1:0] sh;
        p  = PW'($signed(smp)) * PW'($signed({1'b0, q}));
        sh = p >>> GAIN_FRAC;
        if (&sh[PW-1:SAMPLE_W-1] || ~|sh[PW-1:SAMPLE_W-1]) begin
            return sh[SAMPLE_W-1:0];
        end
        return sh[PW-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}}
                        : {1'b0, {(SAMPLE_W-1){1'b1}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sample path signals
    logic [3:0]          wdec;
    logic [3:0]          rdec;
    logic                fire;
    logic [SAMPLE_W-1:0] in_l;
    logic [SAMPLE_W-1:0] in_r;
    logic [SAMPLE_W-1:0] boost_l;
    logic [SAMPLE_W-1:0] boost_r;
    logic [SAMPLE_W-1:0] gain_l;
    logic [SAMPLE_W-1:0] gain_r;
    logic [SAMPLE_W-1:0] sw_l;
    logic [SAMPLE_W-1:0] sw_r;
    logic [7:0]          mode;
    logic [7:0]          boost;
    logic [7:0]          lgain;
    logic [7:0]          rgain;

    assign wdec  = decode(reg_addr);
    assign rdec  = wdec;
    assign mode  = s_reg.regs[IDX_MIC_PORT_MODE];
    assign boost = s_reg.regs[IDX_SECOND_BOOST];
    assign lgain = s_reg.regs[IDX_SECOND_L_GAIN];
    assign rgain = s_reg.regs[IDX_SECOND_R_GAIN];

    // fifo push side follows the converter, pop side the output register
    assign fifo_bus.push_valid = sample_valid;
    assign fifo_bus.push_data  = {sample_left, sample_right};
    assign sample_ready        = fifo_bus.push_ready;
    assign fifo_bus.pop_ready  = !s_reg.ovalid || out_ready;
    assign fire = fifo_bus.pop_valid && fifo_bus.pop_ready;
    assign in_l = fifo_bus.pop_data[2*SAMPLE_W-1:SAMPLE_W];
    assign in_r = fifo_bus.pop_data[SAMPLE_W-1:0];

    sample_fifo #(
        .WIDTH (2 * SAMPLE_W),
        .DEPTH (FIFO_DEP)
    ) u_fifo (
        .mclk (mclk),
        .nrst (nrst),
        .port (fifo_bus.store)
    );

    // boost first, then the inverted-code step gain
    assign boost_l = scale(in_l, BOOST_Q8[boost[LBOOST_LSB+:2]]); // RL9 RL10
    assign boost_r = scale(in_r, BOOST_Q8[boost[RBOOST_LSB+:2]]); // RL10
    assign gain_l = lgain[MUTE_BIT] ? '0 :                         // RL2
        scale(boost_l, STEP_GAIN_Q8[4'hF - lgain[GAIN_LSB+:4]]);  // RL7 RL8
    assign gain_r = rgain[MUTE_BIT] ? '0 :                         // RL2
        scale(boost_r, STEP_GAIN_Q8[4'hF - rgain[GAIN_LSB+:4]]);  // RL7 RL8
    // swap before mono; both in the same stage as the gain
    assign sw_l = mode[EXCH_BIT] ? gain_r : gain_l;               // RL13 RL19
    assign sw_r = mode[MONO_BIT] ? sw_l :                          // RL14 RL17
                  (mode[EXCH_BIT] ? gain_l : gain_r);             // RL13

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_next = s_reg;
        // registers are plain bytes, reserved bits included
        if (reg_wr && wdec[3]) begin
            s_next.regs[wdec[2:0]] = reg_wdata;                   // RL20
        end
        if (reg_rd) begin
            s_next.rdata = rdec[3] ? s_reg.regs[rdec[2:0]] : 8'h00;
        end
        // pin data passes two flops before anyone looks at it
        s_next.sync1    = {shared_pin_in[PIN_DATA_B],
                           shared_pin_in[PIN_DATA_A]};
        s_next.sync2    = s_reg.sync1;
        s_next.mic_bits = s_reg.sync2 ^ {2{mode[INV_BIT]}};       // RL15 RL19
        // mic clock runs only in digital mode, low otherwise
        if (mode[PORT_TYPE_BIT]) begin                            // RL11
            if (s_reg.div_cnt == 8'(CLK_HALF - 1)) begin
                s_next.div_cnt = 8'h00;
                s_next.mic_clk = !s_reg.mic_clk;
            end else begin
                s_next.div_cnt = s_reg.div_cnt + 8'h01;
            end
        end else begin
            s_next.div_cnt = 8'h00;
            s_next.mic_clk = 1'b0;
        end
        // shared pins: data pins are always inputs
        s_next.pin_oe_n = 4'h6;
        s_next.pin_out  = 4'h0;
        if (mode[PORT_TYPE_BIT]) begin                            // RL12
            s_next.pin_out[PIN_CLK_OR_LBIAS]  = s_reg.mic_clk;
            s_next.pin_out[PIN_CSEL_OR_RBIAS] = chan_sel_level;
        end else if (!mode[SHUTDOWN_BIT]) begin                   // RL12 RL16
            s_next.pin_out[PIN_CLK_OR_LBIAS]  = left_bias_level;
            s_next.pin_out[PIN_CSEL_OR_RBIAS] = right_bias_level;
        end else begin
            // powered-down analog port lets the bias pins float
            s_next.pin_oe_n = 4'hF;
        end
        // a muted stage still hands out a (silent) sample
        if (fire) begin
            s_next.ovalid = 1'b1;                                 // RL3
            s_next.oleft  = sw_l;
            s_next.oright = sw_r;
        end else if (out_ready) begin
            s_next.ovalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.regs[IDX_FIRST_R_GAIN]  <= RST_FIRST_R_GAIN;    // RL1 RL2
            s_reg.regs[IDX_FIRST_SRC]     <= RST_FIRST_SRC;       // RL4
            s_reg.regs[IDX_FIRST_FILT]    <= RST_FILT;            // RL5 RL6
            s_reg.regs[IDX_SECOND_L_GAIN] <= RST_SECOND_GAIN;     // RL7
            s_reg.regs[IDX_SECOND_R_GAIN] <= RST_SECOND_GAIN;     // RL7
            s_reg.regs[IDX_SECOND_BOOST]  <= RST_BOOST;           // RL10
            s_reg.regs[IDX_SECOND_FILT]   <= RST_FILT;            // RL5 RL6
            s_reg.regs[IDX_MIC_PORT_MODE]      <= RST_MIC_PORT_MODE;        // RL16
            s_reg.pin_oe_n                <= 4'hF;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata       = s_reg.rdata;
    assign out_valid       = s_reg.ovalid;
    assign out_left        = s_reg.oleft;
    assign out_right       = s_reg.oright;
    assign shared_pin_out  = s_reg.pin_out;
    assign shared_pin_oe_n = s_reg.pin_oe_n;
    assign mic_bit_a       = s_reg.mic_bits[0];
    assign mic_bit_b       = s_reg.mic_bits[1];
    // analog stage levels straight from the registers
    assign first_right_analog_gain =
        s_reg.regs[IDX_FIRST_R_GAIN][GAIN_LSB+:4];                // RL1 RL18
    assign first_right_mute =
        s_reg.regs[IDX_FIRST_R_GAIN][MUTE_BIT];                   // RL2 RL3
    assign first_left_source_sel =
        s_reg.regs[IDX_FIRST_SRC][LEFT_SRC_BIT];                  // RL4
    assign first_right_source_sel =
        s_reg.regs[IDX_FIRST_SRC][RIGHT_SRC_BIT];                 // RL4
    assign first_highpass_hold   = s_reg.regs[IDX_FIRST_FILT][HOLD_BIT]; // RL5
    assign first_highpass_bypass =
        s_reg.regs[IDX_FIRST_FILT][BYPASS_BIT];                   // RL6
    assign second_highpass_hold  =
        s_reg.regs[IDX_SECOND_FILT][HOLD_BIT];                    // RL5
    assign second_highpass_bypass =
        s_reg.regs[IDX_SECOND_FILT][BYPASS_BIT];                  // RL6
    assign mic_port_type       = mode[PORT_TYPE_BIT];             // RL11
    assign analog_mic_shutdown = mode[SHUTDOWN_BIT];              // RL16

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    logic unity;
    assign unity = boost[LBOOST_LSB+:2] == 2'h3 &&
                   boost[RBOOST_LSB+:2] == 2'h3 &&
                   lgain == 8'h0F && rgain == 8'h0F;

    chk_mute_silence: assert property ( // RL2
        fire && lgain[MUTE_BIT] && rgain[MUTE_BIT]
        |=> out_valid && out_left == '0 && out_right == '0)
        else $error("muted stages produced non-zero output");
    chk_stream_alive: assert property ( // RL3
        fire |=> out_valid)
        else $error("sample taken but no output presented");
    chk_mono_copy: assert property ( // RL14
        fire && mode[MONO_BIT] |=> out_left == out_right)
        else $error("mono output channels differ");
    chk_unity_pass: assert property ( // RL7
        fire && unity && !mode[EXCH_BIT] && !mode[MONO_BIT]
        |=> out_left == $past(in_l) && out_right == $past(in_r))
        else $error("unity gain path altered samples");
    chk_swap_pass: assert property ( // RL13
        fire && unity && mode[EXCH_BIT] && !mode[MONO_BIT]
        |=> out_left == $past(in_r) && out_right == $past(in_l))
        else $error("swap did not exchange channels");
    chk_invert_path: assert property ( // RL15
        mode[INV_BIT] [*4]
        |-> mic_bit_a != $past(shared_pin_in[PIN_DATA_A], 3))
        else $error("mic bit not inverted");
    chk_gain_write: assert property ( // RL1
        reg_wr && reg_addr == (PAGE_BASE | 16'(OFF_FIRST_R_GAIN))
        |=> first_right_analog_gain == $past(reg_wdata[3:0]))
        else $error("analog gain field not updated");
    chk_source_write: assert property ( // RL4
        reg_wr && reg_addr == (PAGE_BASE | 16'(OFF_FIRST_SRC))
        |=> first_left_source_sel == $past(reg_wdata[0]) &&
            first_right_source_sel == $past(reg_wdata[4]))
        else $error("source select not updated");
    chk_mode_readback: assert property ( // RL20
        reg_wr && reg_addr == (PAGE_BASE | 16'(OFF_MIC_PORT_MODE)) ##1
        !reg_wr && $stable(reg_addr) ##1
        reg_rd && !reg_wr && $stable(reg_addr)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("mode register readback mismatch");
    chk_digital_pins: assert property ( // RL12
        mode[PORT_TYPE_BIT] [*2]
        |-> shared_pin_out[PIN_CSEL_OR_RBIAS] == $past(chan_sel_level) &&
            shared_pin_oe_n == 4'h6)
        else $error("digital mode pin function wrong");
endmodule

// *** test/capture_host_model.sv ***
// Purpose: host side of the register port
// Assumes: strobes sampled on the rising mclk edge
// Notes:   idle cycle after each strobe, never re-raised in one step
`timescale 1ns/1ns
module capture_host_model (
    input  wire logic        mclk,
    output logic      [15:0] reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [7:0]  reg_wdata
);
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one-cycle strobes launched off the falling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(negedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(negedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(negedge mclk);
        reg_rd <= 1'b0;
    endtask
endmodule

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the capture path block
// Assumes: host model owns the register port
// Notes:   small positive samples, so no stage saturates
`timescale 1ns/1ns
module tb_top;
    import capture_path_pkg::*;
    logic mclk = 0, nrst = 0, reg_wr, reg_rd, rd_p = 0, hold = 1, ok, p, t;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, gl, gr, bs, md, v;
    logic sample_valid = 0, sample_ready, out_valid, out_ready = 0;
    logic [23:0] sample_left = 0, sample_right = 0, out_left, out_right;
    logic [3:0] shared_pin_in = 0, shared_pin_out, shared_pin_oe_n;
    logic [3:0] first_right_analog_gain;
    logic left_bias_level = 1, right_bias_level = 0, chan_sel_level = 1;
    logic mic_bit_a, mic_bit_b, first_right_mute, first_left_source_sel;
    logic first_right_source_sel, first_highpass_hold, first_highpass_bypass;
    logic second_highpass_hold, second_highpass_bypass, mic_port_type;
    logic analog_mic_shutdown;
    logic [47:0] rq[$], sq[$], e;
    logic [7:0] rst_v[8] = '{8'h80, 8'h00, 8'h00, 8'h8F, 8'h8F, 8'h33,
                             8'h00, 8'h80};
    int n_mismatch = 0, samples_checked = 0, n;

    capture_path_ctrl #(.CLK_HALF(2)) DUT (.*);
    capture_host_model host (.*);
    always #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(string s, logic [47:0] x, logic [47:0] g);
        samples_checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("FAIL %s exp %h got %h", s, x, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bail();
        n_mismatch++;
        complete_run();
    endtask
    // watcher: read data a cycle after strobe, samples on handshake
    always @(posedge mclk) begin
        if (rd_p) begin
            e = rq.pop_front();
            cmp("reg_rdata", e, 48'(reg_rdata));
        end
        rd_p <= reg_rd;
        if (out_valid && out_ready) begin
            e = sq.pop_front();
            cmp("sample", e, {out_left, out_right});
        end
    end
    // consumer stalls at random unless held off
    always @(negedge mclk) out_ready <= !hold && ($urandom % 4 != 0);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] gain(logic [23:0] x, logic [1:0] b,
                                         logic [3:0] g);
        logic [47:0] y;
        y = (48'(x) * BOOST_Q8[b]) >> 8;
        y = (y * STEP_GAIN_Q8[4'hF - g]) >> 8;
        return y[23:0];
    endfunction
    task automatic rdchk(logic [15:0] a, logic [7:0] x);
        rq.push_back(48'(x));
        host.rd(a);
    endtask
    task automatic cfg(logic [7:0] l, r, b, m);
        {gl, gr, bs, md} = {l, r, b, m};
        host.wr(16'hA1B4, l);
        host.wr(16'hA1B5, r);
        host.wr(16'hA1B6, b);
        host.wr(16'hA1B8, m);
    endtask
    // sample held for up to tries cycles; the note is made only on acceptance
    task automatic offer(int tries, output logic acc);
        logic [23:0] a, c;
        @(negedge mclk);
        sample_valid = 1;
        sample_left = 24'($urandom % 4096);
        sample_right = 24'($urandom % 4096);
        acc = 0;
        for (int k = 0; k < tries && !acc; k++) begin
            @(posedge mclk);
            acc = sample_ready;
        end
        a = gl[7] ? 24'h0 : gain(sample_left, bs[5:4], gl[3:0]);
        c = gr[7] ? 24'h0 : gain(sample_right, bs[1:0], gr[3:0]);
        if (md[1]) {a, c} = {c, a};
        if (md[2]) c = a;
        if (acc) sq.push_back({a, c});
    endtask
    task automatic stream(int cnt);
        for (int i = 0; i < cnt; i++) begin
            offer(50, ok);
            if (!ok) bail();
        end
        @(negedge mclk);
        sample_valid = 0;
        for (int k = 0; k < 300 && sq.size() > 0; k++) @(posedge mclk);
        if (sq.size() > 0) bail();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(13));
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        nrst = 1;
        cmp("fields", 3'b110, {first_right_mute, analog_mic_shutdown,
            mic_port_type});
        for (int i = 0; i < 8; i++) rdchk(16'hA1B1 + 16'(i), rst_v[i]);
        rdchk(16'hA1B9, 8'h00);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            host.wr(16'hA1B1 + 16'(i), v);
            rdchk(16'hA1B1 + 16'(i), v);
        end
        host.wr(16'hA1B1, 8'h0A);
        host.wr(16'hA1B2, 8'h11);
        host.wr(16'hA1B3, 8'h50);
        host.wr(16'hA1B7, 8'h50);
        cmp("gain", 5'h0A, {first_right_mute, first_right_analog_gain});
        cmp("ctl", 6'h3F, {first_left_source_sel, first_right_source_sel,
            first_highpass_hold, first_highpass_bypass, second_highpass_hold,
            second_highpass_bypass});
        $display("test registers done");
        hold = 0;
        for (int m = 0; m < 4; m++) begin
            cfg(8'h0F, 8'h0F, 8'h33, 8'(m << 1));
            stream(6);
        end
        cfg(8'h00, 8'h8F, 8'h03, 8'h00);
        stream(6);
        cfg(8'h07, 8'h0B, 8'h12, 8'h00);
        stream(6);
        cfg(8'h8F, 8'h8F, 8'h33, 8'h00);
        stream(2);
        $display("test stream done");
        hold = 1;
        repeat (2) @(negedge mclk);
        n = 0;
        ok = 1;
        while (ok && n < 20) begin
            offer(1, ok);
            n += int'(ok);
        end
        cmp("fill", FIFO_DEPTH + 2, n);
        hold = 0;
        stream(0);
        $display("test buffer done");
        host.wr(16'hA1B8, 8'h01);
        repeat (3) @(negedge mclk);
        cmp("oe_dig", 4'h6, shared_pin_oe_n);
        cmp("csel", 1, shared_pin_out[3]);
        p = shared_pin_out[0];
        t = 0;
        repeat (6) @(negedge mclk) t |= (shared_pin_out[0] !== p);
        cmp("mic_clk", 1, t);
        host.wr(16'hA1B8, 8'h00);
        repeat (3) @(negedge mclk);
        cmp("oe_ana", 4'h6, shared_pin_oe_n);
        cmp("bias", 2'b10, {shared_pin_out[0], shared_pin_out[3]});
        host.wr(16'hA1B8, 8'h88);
        shared_pin_in = 4'b0010;
        repeat (5) @(negedge mclk);
        cmp("oe_off", 4'hF, shared_pin_oe_n);
        cmp("invert", 2'b01, {mic_bit_a, mic_bit_b});
        $display("test pins done");
        complete_run();
    end
endmodule
